// >>> pprb_pkg.sv
package pprb_pkg;
   // =====================================================
   // register addresses
   localparam logic [1:0] ADDR_WIPER = 2'h0;
   localparam logic [1:0] ADDR_MODE = 2'h1;
   localparam logic [1:0] ADDR_ACCESS = 2'h2;
   // =====================================================
   // field positions
   localparam int ACC_VOL_BIT = 7;
   localparam int ACC_SHUTDOWN_CONTROL_BIT = 6;
   localparam int ACC_WIP_BIT = 5;
   localparam int MODE_DIV_BIT = 7;
   localparam int MODE_PREC_OFF_BIT = 6;
   localparam int ADDR_SEL_BIT = 2;
   // =====================================================
   // reset and factory values
   localparam logic [6:0] WIPER_POR = 7'h40;
   localparam logic [7:0] IVR_FACTORY = 8'h40;
   localparam logic [7:0] MODE_FACTORY = 8'h00;
   localparam logic VOL_RESET = 1'b0;
   localparam logic SHUTDOWN_CONTROL_RESET = 1'b1;
   localparam logic [6:0] SLAVE_ADDR_BASE = 7'h50;
   // =====================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int NV_WRITE_TIME_MS = 20;
   localparam int NV_WRITE_CYCLES =
      NV_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RECALL_TIME_NS = 1000;
   localparam int RECALL_CYCLES =
      (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> pprb_sync.sv
`timescale 1ns/1ns
// =====================================================
// two-flop synchroniser for pin inputs
module pprb_sync #(
   parameter int WIDTH = 3
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_r;

   initial
   begin
      if (WIDTH < 1)
         $error("pprb_sync: WIDTH must be at least 1");
   end

   // idle bus level is high, so reset to ones avoids a fake start
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_r <= '1;
         sync_o <= '1;
      end
      else
      begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule

// >>> pprb_tap_decoder.sv
`timescale 1ns/1ns
// =====================================================
// one-hot tap switch drive with make before break
module pprb_tap_decoder #(
   parameter int CODE_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [CODE_W-1:0] code_i,
   output logic [(1<<CODE_W)-1:0] tap_o
);
   localparam int TAPS = 1 << CODE_W;
   logic [CODE_W-1:0] cur_r;
   logic [TAPS-1:0] tap_nxt;

   initial
   begin
      if (CODE_W < 1 || CODE_W > 10)
         $error("pprb_tap_decoder: CODE_W out of range");
   end

   // new tap joins the old one first, old drops a cycle later
   for (genvar t = 0; t < TAPS; t++)
   begin : g_tap
      assign tap_nxt[t] = (code_i == CODE_W'(t)) ||
         ((cur_r != code_i) && (cur_r == CODE_W'(t)));
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cur_r <= pprb_pkg::WIPER_POR[CODE_W-1:0];
         tap_o <= TAPS'(1) << pprb_pkg::WIPER_POR;
      end
      else
      begin
         cur_r <= code_i;
         tap_o <= tap_nxt;
      end
   end

   property p_make_before_break;
      @(posedge clk_i) disable iff (!rst_n_i)
      (code_i != cur_r) |=> (tap_o[$past(cur_r)] && tap_o[$past(code_i)]);
   endproperty
   a_make_before_break: assert property (p_make_before_break)
      else $error("old and new taps not both closed on a change");

   property p_single_tap;
      @(posedge clk_i) disable iff (!rst_n_i)
      ($stable(code_i) && code_i == cur_r) |=>
         (tap_o == (TAPS'(1) << $past(code_i)));
   endproperty
   a_single_tap: assert property (p_single_tap)
      else $error("steady code does not select exactly its tap");
endmodule

// >>> pprb_top.sv
`timescale 1ns/1ns
module pprb_top #(
   parameter int NV_WRITE_CYC = pprb_pkg::NV_WRITE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic factory_init_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic address_select_pin_i,
   output logic [6:0] wiper_code_o,
   output logic [127:0] tap_sel_o,
   output logic shutdown_control_o,
   output logic divider_mode_o,
   output logic precision_off_o,
   output logic write_in_progress_o
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_ID, ST_ID_ACK, ST_REG, ST_REG_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_WAIT
   } pprb_state_t;

   initial
   begin
      if (NV_WRITE_CYC < 1 || NV_WRITE_CYC > 4194303)
         $error("pprb_top: NV_WRITE_CYC out of range");
   end

   // =====================================================
   // pin synchronisers and bus event detection
   logic [2:0] pin_s;
   logic scl_s, sda_s, a1_s;
   logic scl_q_r, sda_q_r;
   logic scl_rise, scl_fall, bus_start, bus_stop;

   pprb_sync #(.WIDTH(3)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i({scl_i, sda_i, address_select_pin_i}),
      .sync_o(pin_s)
   );
   assign scl_s = pin_s[2];
   assign sda_s = pin_s[1];
   assign a1_s = pin_s[0];

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   // start and stop are data edges while the clock stays high
   assign scl_rise = scl_s && !scl_q_r;
   assign scl_fall = !scl_s && scl_q_r;
   assign bus_start = scl_s && scl_q_r && sda_q_r && !sda_s;
   assign bus_stop = scl_s && scl_q_r && !sda_q_r && sda_s;

   // =====================================================
   // register state
   logic [7:0] ivr_r;
   logic [1:0] mode_r;
   logic [6:0] wiper_r;
   logic vol_r, shutdown_control_r, wip_r;
   logic [21:0] nv_cnt_r;
   logic [7:0] recall_cnt_r;
   logic recall_done_r;
   logic pend_r;
   logic [1:0] pend_addr_r;
   logic [7:0] pend_data_r;
   logic commit, nv_commit, wiper_commit, acc_commit;
   logic [7:0] rdata;

   // every write lands at the stop; busy blocks all of them
   assign commit = bus_stop && pend_r && !wip_r;
   assign nv_commit = commit && ((pend_addr_r == pprb_pkg::ADDR_WIPER &&
      !vol_r) || pend_addr_r == pprb_pkg::ADDR_MODE);
   assign wiper_commit = commit && pend_addr_r == pprb_pkg::ADDR_WIPER;
   assign acc_commit = commit && pend_addr_r == pprb_pkg::ADDR_ACCESS;

   // non-volatile cells: only the factory init loads their factory values
   always_ff @(posedge clk_i or negedge factory_init_n_i)
   begin
      if (!factory_init_n_i)
      begin
         ivr_r <= pprb_pkg::IVR_FACTORY;
         mode_r <= pprb_pkg::MODE_FACTORY[7:6];
      end
      else if (nv_commit && pend_addr_r == pprb_pkg::ADDR_WIPER)
         ivr_r <= pend_data_r;
      else if (nv_commit)
         mode_r <= pend_data_r[7:6];
   end

   // power-up recall after the supply settles
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         recall_cnt_r <= 8'h00;
         recall_done_r <= 1'b0;
      end
      else if (!recall_done_r)
      begin
         recall_cnt_r <= recall_cnt_r + 8'h01;
         if (recall_cnt_r == 8'(pprb_pkg::RECALL_CYCLES - 1))
            recall_done_r <= 1'b1;
      end
   end

   // wiper: mid-scale at power-up, then recalled, then written
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wiper_r <= pprb_pkg::WIPER_POR;
      else if (!recall_done_r &&
         recall_cnt_r == 8'(pprb_pkg::RECALL_CYCLES - 1))
         wiper_r <= ivr_r[6:0];
      else if (wiper_commit)
         wiper_r <= pend_data_r[6:0];
   end

   // access control flags
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         vol_r <= pprb_pkg::VOL_RESET;
         shutdown_control_r <= pprb_pkg::SHUTDOWN_CONTROL_RESET;
      end
      else if (acc_commit)
      begin
         vol_r <= pend_data_r[pprb_pkg::ACC_VOL_BIT];
         shutdown_control_r <= pend_data_r[pprb_pkg::ACC_SHUTDOWN_CONTROL_BIT];
      end
   end

   // self-timed write; worst-case time is always waited out
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wip_r <= 1'b0;
         nv_cnt_r <= 22'h00_0000;
      end
      else if (nv_commit)
      begin
         wip_r <= 1'b1;
         nv_cnt_r <= 22'(NV_WRITE_CYC);
      end
      else if (wip_r)
      begin
         nv_cnt_r <= nv_cnt_r - 22'h00_0001;
         if (nv_cnt_r == 22'h00_0001)
            wip_r <= 1'b0;
      end
   end

   // read mux; reserved bits read as zero, except wiper bit 7, which reads back ivr_r bit 7 while vol_r is clear
   always_comb
   begin
      case (pend_addr_r)
         pprb_pkg::ADDR_WIPER:
            rdata = vol_r ? {1'b0, wiper_r} : ivr_r;
         pprb_pkg::ADDR_MODE:
            rdata = {mode_r, 6'h00};
         pprb_pkg::ADDR_ACCESS:
            rdata = {vol_r, shutdown_control_r, wip_r, 5'h00};
         default:
            rdata = 8'h00;
      endcase
   end

   // =====================================================
   // serial slave engine
   pprb_state_t state_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [3:0] cnt_r;
   logic mack_r;
   logic id_match;

   assign id_match = shift_r[7:1] == (pprb_pkg::SLAVE_ADDR_BASE |
      (7'(a1_s) << pprb_pkg::ADDR_SEL_BIT));

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= ST_IDLE;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         cnt_r <= 4'h0;
         mack_r <= 1'b0;
         sda_oe_o <= 1'b0;
         pend_r <= 1'b0;
         pend_addr_r <= 2'h0;
         pend_data_r <= 8'h00;
      end
      else if (bus_stop)
      begin
         state_r <= ST_IDLE;
         sda_oe_o <= 1'b0;
         pend_r <= 1'b0;
      end
      else if (bus_start && recall_done_r)
      begin
         state_r <= ST_ID;
         cnt_r <= 4'h0;
         sda_oe_o <= 1'b0;
         pend_r <= 1'b0;
      end
      else if (scl_rise)
      begin
         // inputs are taken on the rising clock edge
         if (state_r == ST_ID || state_r == ST_REG ||
            state_r == ST_WDATA || state_r == ST_RDATA)
         begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
         end
         else if (state_r == ST_RACK)
            mack_r <= !sda_s;
      end
      else if (scl_fall)
      begin
         // outputs change only after the falling clock edge
         case (state_r)
            ST_ID:
               if (cnt_r == 4'h8)
               begin
                  state_r <= id_match ? ST_ID_ACK : ST_WAIT;
                  sda_oe_o <= id_match;
               end
            ST_ID_ACK:
            begin
               cnt_r <= 4'h0;
               if (shift_r[0])
               begin
                  state_r <= ST_RDATA;
                  tx_r <= rdata;
                  sda_oe_o <= !rdata[7];
               end
               else
               begin
                  state_r <= ST_REG;
                  sda_oe_o <= 1'b0;
               end
            end
            ST_REG:
               if (cnt_r == 4'h8)
               begin
                  state_r <= ST_REG_ACK;
                  pend_addr_r <= shift_r[1:0];
                  sda_oe_o <= 1'b1;
               end
            ST_REG_ACK:
            begin
               state_r <= ST_WDATA;
               cnt_r <= 4'h0;
               sda_oe_o <= 1'b0;
            end
            ST_WDATA:
               if (cnt_r == 4'h8)
               begin
                  state_r <= ST_WDATA_ACK;
                  pend_r <= 1'b1;
                  pend_data_r <= shift_r;
                  sda_oe_o <= 1'b1;
               end
            ST_WDATA_ACK:
            begin
               state_r <= ST_WAIT;
               sda_oe_o <= 1'b0;
            end
            ST_RDATA:
               if (cnt_r == 4'h8)
               begin
                  state_r <= ST_RACK;
                  sda_oe_o <= 1'b0;
               end
               else
                  sda_oe_o <= !tx_r[3'(4'h7 - cnt_r)];
            ST_RACK:
               if (mack_r)
               begin
                  state_r <= ST_RDATA;
                  cnt_r <= 4'h0;
                  tx_r <= rdata;
                  sda_oe_o <= !rdata[7];
               end
               else
                  state_r <= ST_WAIT;
            default:
               sda_oe_o <= 1'b0;
         endcase
      end
   end

   // =====================================================
   // outputs, all registered
   pprb_tap_decoder #(.CODE_W(7)) u_tap (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .code_i(wiper_r),
      .tap_o(tap_sel_o)
   );

   // pin only ever pulls low, never drives high
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sda_o <= 1'b0;
         wiper_code_o <= pprb_pkg::WIPER_POR;
         shutdown_control_o <= pprb_pkg::SHUTDOWN_CONTROL_RESET;
         divider_mode_o <= 1'b0;
         precision_off_o <= 1'b0;
         write_in_progress_o <= 1'b0;
      end
      else
      begin
         sda_o <= 1'b0;
         wiper_code_o <= wiper_r;
         shutdown_control_o <= shutdown_control_r;
         divider_mode_o <= mode_r[1];
         precision_off_o <= mode_r[0];
         write_in_progress_o <= wip_r;
      end
   end

   // =====================================================
   // checks
   property p_open_drain;
      @(posedge clk_i) disable iff (!rst_n_i) sda_oe_o |-> !sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data pin driven high");

   property p_por_mid;
      @(posedge clk_i) disable iff (!rst_n_i)
      !recall_done_r |-> wiper_r == pprb_pkg::WIPER_POR;
   endproperty
   a_por_mid: assert property (p_por_mid)
      else $error("wiper not mid-scale before recall");

   property p_recall;
      @(posedge clk_i) disable iff (!rst_n_i)
      $rose(recall_done_r) |-> wiper_r == ivr_r[6:0];
   endproperty
   a_recall: assert property (p_recall)
      else $error("wiper not loaded from initial value");

   property p_wip_start;
      @(posedge clk_i) disable iff (!rst_n_i)
      nv_commit |=> wip_r ##1 write_in_progress_o;
   endproperty
   a_wip_start: assert property (p_wip_start)
      else $error("busy flag not set after stop");

   property p_wip_end;
      @(posedge clk_i) disable iff (!rst_n_i)
      (wip_r && nv_cnt_r == 22'h00_0001) |=> !wip_r ##1 !write_in_progress_o;
   endproperty
   a_wip_end: assert property (p_wip_end)
      else $error("busy flag did not clear at end of write");

   property p_wip_blocks;
      @(posedge clk_i) disable iff (!rst_n_i)
      wip_r && recall_done_r |=> $stable(vol_r) && $stable(shutdown_control_r) &&
         $stable(wiper_r);
   endproperty
   a_wip_blocks: assert property (p_wip_blocks)
      else $error("write accepted while busy");

   property p_mirror;
      @(posedge clk_i) disable iff (!rst_n_i)
      (nv_commit && pend_addr_r == pprb_pkg::ADDR_WIPER) |=>
         wiper_r == ivr_r[6:0];
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("initial value write did not reach wiper");

   property p_addr_ack;
      @(posedge clk_i) disable iff (!rst_n_i)
      (scl_fall && state_r == ST_ID && cnt_r == 4'h8) |=>
         sda_oe_o == $past(id_match);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("acknowledge does not follow address match");

   property p_vol_target;
      @(posedge clk_i) disable iff (!rst_n_i)
      (commit && vol_r && pend_addr_r == pprb_pkg::ADDR_WIPER) |=>
         $stable(ivr_r) && !wip_r;
   endproperty
   a_vol_target: assert property (p_vol_target)
      else $error("volatile-only write touched initial value");
endmodule

// >>> pprb_bus_master.sv
`timescale 1ns/1ns
// =====================================================
// behavioural bus master on the serial clock and data pins
module pprb_bus_master #(
   parameter int HALF = 8
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // both lines start released; the clock stands high between frames
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // one bus phase; pins change just after a system clock edge
   task automatic ph(input logic scl, input logic oe);
      repeat (HALF) @(posedge clk_i);
      scl_o <= scl;
      sda_oe_o <= oe;
   endtask
   // data moves only while the clock is low, read halfway through the high phase
   task automatic bitx(input logic oe, output logic v);
      ph(1'b0, sda_oe_o);
      ph(1'b0, oe);
      ph(1'b1, oe);
      repeat (HALF) @(posedge clk_i);
      v = sda_i;
   endtask
   // start and repeated start: data falls while the clock is high
   task automatic start();
      ph(1'b0, sda_oe_o);
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      ph(1'b0, sda_oe_o);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   // byte out, msb first, then the slave's acknowledge
   task automatic wr(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--)
         bitx(!b[i], v);
      bitx(1'b0, v);
      ack = !v;
   endtask
   // byte in; the last byte is refused so the slave lets go
   task automatic rd(input logic last, output logic [7:0] b);
      logic v;
      for (int i = 7; i >= 0; i--)
         bitx(1'b0, b[i]);
      bitx(!last, v);
   endtask
   // write frame: id, register byte, one data byte, stop
   task automatic write_reg(input logic [6:0] sid, input logic [7:0] ra,
      input logic [7:0] d, output logic [2:0] a);
      start();
      wr({sid, 1'b0}, a[2]);
      wr(ra, a[1]);
      wr(d, a[0]);
      stop();
   endtask
   // read frame: id(w), register byte, repeated start, id(r), one byte
   task automatic read_reg(input logic [6:0] sid, input logic [7:0] ra,
      output logic [7:0] d, output logic [2:0] a);
      start();
      wr({sid, 1'b0}, a[2]);
      wr(ra, a[1]);
      start();
      wr({sid, 1'b1}, a[0]);
      rd(1'b1, d);
      stop();
   endtask
endmodule

// >>> test_pprb_top.sv
`timescale 1ns/1ns
module test_pprb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fac_n = 1'b0;
   logic pin = 1'b0;
   logic scl;
   logic m_oe;
   logic d_o;
   logic d_oe;
   logic [6:0] code;
   logic [127:0] tap;
   logic shutdown_control;
   logic div;
   logic poff;
   logic write_in_progress;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;
   // pull-up: the line is low only while some party pulls it
   wire sda = !(m_oe || d_oe);
   wire [6:0] sid = pprb_pkg::SLAVE_ADDR_BASE | {4'h0, pin, 2'b00};
   always #5 clk = !clk;
   // busy time must outlast one whole write frame so a write can hit it
   pprb_top #(.NV_WRITE_CYC(1500)) uut (.clk_i(clk), .rst_n_i(rst_n),
      .factory_init_n_i(fac_n), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
      .sda_oe_o(d_oe), .address_select_pin_i(pin), .wiper_code_o(code),
      .tap_sel_o(tap), .shutdown_control_o(shutdown_control), .divider_mode_o(div),
      .precision_off_o(poff), .write_in_progress_o(write_in_progress));
   pprb_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl),
      .sda_oe_o(m_oe));
   // =====================================================
   // reporting
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t byte got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   task automatic chk_tap(input logic [127:0] e);
      tests_run++;
      if (tap !== e)
      begin
         bad_count++;
         $display("[ERR] %0t tap select wrong", $time);
      end
   endtask
   // =====================================================
   // register access; every frame expects three acknowledges
   task automatic wreg(input logic [7:0] ra, input logic [7:0] d);
      logic [2:0] a;
      m.write_reg(sid, ra, d, a);
      chk8({5'h0, a}, 8'h07);
      // stop seen after sync, commit, then registered outputs
      repeat (6) @(posedge clk);
   endtask
   task automatic rreg(input logic [7:0] ra, output logic [7:0] d);
      logic [2:0] a;
      m.read_reg(sid, ra, d, a);
      chk8({5'h0, a}, 8'h07);
   endtask
   // bounded wait for the self-timed write to finish
   task automatic wait_nv;
      int n;
      n = 0;
      while (write_in_progress !== 1'b0 && n < 2000)
      begin
         @(posedge clk);
         n++;
      end
      chk1(write_in_progress, 1'b0);
   endtask
   // =====================================================
   // scenarios
   task automatic t_reset;
      logic [7:0] d;
      chk8({1'b0, code}, 8'h40);
      chk_tap(128'h1 << 64);
      chk1(shutdown_control, 1'b1);
      chk1(div, 1'b0);
      chk1(poff, 1'b0);
      rreg(8'h02, d);
      chk8(d, 8'h40);
      rreg(8'h03, d);
      chk8(d, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_addr;
      logic [2:0] a;
      // wrong pin bit: every byte goes unanswered and nothing changes
      m.write_reg(sid ^ 7'h04, 8'h02, 8'h00, a);
      chk8({5'h0, a}, 8'h00);
      repeat (4) @(posedge clk);
      chk1(shutdown_control, 1'b1);
      $display("test address done");
   endtask
   task automatic t_nv;
      logic [7:0] d;
      wreg(8'h00, 8'h7F);
      chk1(write_in_progress, 1'b1);
      chk8({1'b0, code}, 8'h7F);
      chk_tap(128'h1 << 127);
      // access write while busy is acknowledged yet dropped
      wreg(8'h02, 8'hC0);
      wait_nv();
      rreg(8'h02, d);
      chk8(d, 8'h40);
      rreg(8'h00, d);
      chk8(d, 8'h7F);
      $display("test nv write done");
   endtask
   task automatic t_vol;
      logic [7:0] d;
      wreg(8'h02, 8'hC0);
      wreg(8'h00, 8'h00);
      chk8({1'b0, code}, 8'h00);
      chk1(write_in_progress, 1'b0);
      rreg(8'h00, d);
      chk8(d, 8'h00);
      rreg(8'h02, d);
      chk8(d, 8'hC0);
      // power cycle: mid value first, then the stored value
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk8({1'b0, code}, 8'h40);
      repeat (120) @(posedge clk);
      chk8({1'b0, code}, 8'h7F);
      rreg(8'h02, d);
      chk8(d, 8'h40);
      $display("test volatile done");
   endtask
   task automatic t_mode;
      logic [7:0] d;
      wreg(8'h01, 8'hFF);
      chk1(div, 1'b1);
      chk1(poff, 1'b1);
      wait_nv();
      rreg(8'h01, d);
      chk8(d & 8'hC0, 8'hC0);
      wreg(8'h01, 8'h00);
      wait_nv();
      chk1(div, 1'b0);
      $display("test mode done");
   endtask
   task automatic t_shutdown_control;
      wreg(8'h02, 8'h00);
      chk1(shutdown_control, 1'b0);
      wreg(8'h02, 8'h40);
      chk1(shutdown_control, 1'b1);
      $display("test shutdown done");
   endtask
   task automatic t_pin;
      logic [7:0] d;
      logic [2:0] a;
      pin <= 1'b1;
      repeat (8) @(posedge clk);
      rreg(8'h02, d);
      chk8(d, 8'h40);
      m.write_reg(pprb_pkg::SLAVE_ADDR_BASE, 8'h02, 8'h00, a);
      chk8({5'h0, a}, 8'h00);
      $display("test pin done");
   endtask
   // =====================================================
   // hang guard and main sequence
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         bad_count++;
         end_sim();
      end
   end
   initial
   begin
      repeat (2) @(posedge clk);
      fac_n <= 1'b1;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (120) @(posedge clk);
      t_reset();
      t_addr();
      t_nv();
      t_vol();
      t_mode();
      t_shutdown_control();
      t_pin();
      end_sim();
   end
endmodule
